// file: rtl/pdb_top.sv
// Top of the PLL output divider bank with its Avalon-MM control registers.
// Overview of operation
// - Three banks of four outputs plus one separate, independently selected feedback output.
// - Each bank divides the VCO clock by its selected divide number.
// - Prediv select in halving setting inserts divide by two ahead of all dividers.
// - Feedback is taken only from an external pin; no internal feedback path.
// - Range bit doubles the feedback divide, doubling outputs relative to reference.
// - Feedback divider offers seven distinct divides over its eight codes.
// - Invert control inverts bank C outputs two and three for 180 degree clocks.
// - Lock is flagged no later than 10 ms after feedback and configuration valid.
// - Bank select codes give A 4,6,8,12; B 4,6,8,10; C 2,4,6,8.
// - Feedback codes give 4,6,8,10, or 8,12,16,20 with range bit set.
// - Frozen outputs held low while counting; freeze changes only while output low.
// - Sync low one faster period, one such period before A/C coincident rises.
//
// The implementer's own choices: the register addresses and the Avalon-MM register port.
`default_nettype none
module pdb_top
  import pdb_pkg::*;
#(
  parameter int unsigned LOCK_CYCLES = LOCK_CYCLES_DFLT
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        freeze_clk_i,
  input  wire logic        freeze_data_i,
  input  wire logic        fb_return_i,
  output logic [3:0]       bank_a_outputs_o,
  output logic [3:0]       bank_b_outputs_o,
  output logic [3:0]       bank_c_outputs_o,
  output logic             feedback_output_o,
  output logic             sync_n_o,
  output logic             outputs_enable_o,
  output logic             pll_locked_o
);
  localparam int LCW = $clog2(LOCK_CYCLES + 1);

  // Bus slave
  logic              wait_ff;
  logic              nxt_wait;
  logic [31:0]       rdata_ff;
  logic [31:0]       nxt_rdata;
  logic [CTRL_W-1:0] ctrl_ff;
  logic [CTRL_W-1:0] nxt_ctrl;
  logic              req;
  logic              sel_ctrl;
  logic              sel_status;
  logic              wr_ctrl;
  logic [31:0]       status_word;

  // Clock generation
  logic              half_ff;
  logic              tick;
  logic              clr;
  logic              resync;
  logic              div_clr;
  logic              mroe;
  pdb_div_t          div_n [N_DIV];
  logic [N_DIV-1:0]  q;
  logic [N_OUT-1:0]  raw;

  // Sync
  logic [SUP_W-1:0]  sup_ff;
  logic [SUP_W-1:0]  nxt_sup;
  logic              sup_start_ff;
  logic              nxt_sup_start;
  logic [SUP_W-1:0]  sup_len;
  logic [SUP_W-1:0]  fast_per;
  logic              sup_wrap;
  logic              sync_n_ff;
  logic              nxt_sync_n;
  logic [5:0]        sync_lo_ff;

  // Output gating
  logic [N_OUT-1:0]  frz_mask;
  logic [N_OUT-1:0]  inv_tgt;
  logic [N_OUT-1:0]  inv_eff_ff;
  logic [N_OUT-1:0]  nxt_inv_eff;
  logic [N_OUT-1:0]  frz_eff_ff;
  logic [N_OUT-1:0]  nxt_frz_eff;
  logic [N_OUT-1:0]  vis;
  logic [N_OUT-1:0]  out_ff;
  logic [N_OUT-1:0]  nxt_out;
  logic              oe_ff;

  // Lock monitor
  logic              fb_prev_ff;
  logic [FB_WATCH_W-1:0] fb_watch_ff;
  logic [FB_WATCH_W-1:0] nxt_fb_watch;
  logic              fb_active;
  logic [LCW-1:0]    lock_cnt_ff;
  logic [LCW-1:0]    nxt_lock_cnt;
  logic              lock_restart;
  logic              lock_ff;

  // Register bus: one wait cycle, then the answer
  assign req         = avs_read_i | avs_write_i;
  assign nxt_wait    = ~(req & wait_ff);
  assign sel_ctrl    = (avs_address_i[3:2] == OFF_CTRL[3:2]);
  assign sel_status  = (avs_address_i[3:2] == OFF_STATUS[3:2]);
  assign wr_ctrl     = avs_write_i & ~wait_ff & sel_ctrl;
  assign nxt_ctrl    = wr_ctrl ? {avs_byteenable_i[1] ? avs_writedata_i[11:8] : ctrl_ff[11:8],
                                  avs_byteenable_i[0] ? avs_writedata_i[7:0]  : ctrl_ff[7:0]} : ctrl_ff;
  assign status_word = {3'h0, frz_eff_ff, 13'h0000, sync_n_ff, fb_active, lock_ff};
  assign nxt_rdata   = (avs_read_i && wait_ff) ? (sel_ctrl   ? {20'h00000, ctrl_ff} :
                                                  sel_status ? status_word : 32'h00000000) : rdata_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h00000000;
      ctrl_ff  <= CTRL_RST;
    end else begin
      wait_ff  <= nxt_wait;
      rdata_ff <= nxt_rdata;
      ctrl_ff  <= nxt_ctrl;
    end
  end

  // Divider setup
  assign mroe     = ctrl_ff[CTRL_MROE];
  assign clr      = ~mroe;
  // Select change restarts every divider, else A and C drift apart from sync
  assign resync   = wr_ctrl & (nxt_ctrl[CTRL_INV-1:0] != ctrl_ff[CTRL_INV-1:0]);
  assign div_clr  = clr | resync;
  // Low prediv select halves the tick rate for every divider alike
  assign tick     = ctrl_ff[CTRL_VCO] | half_ff;
  assign div_n[0] = pdb_bank_div(2'h0, ctrl_ff[CTRL_A_LSB +: 2]);
  assign div_n[1] = pdb_bank_div(2'h1, ctrl_ff[CTRL_B_LSB +: 2]);
  assign div_n[2] = pdb_bank_div(2'h2, ctrl_ff[CTRL_C_LSB +: 2]);
  assign div_n[3] = pdb_fb_div(ctrl_ff[CTRL_RANGE], ctrl_ff[CTRL_FB_LSB +: 2]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      half_ff <= 1'b1;
    end else begin
      half_ff <= clr ? 1'b1 : ~half_ff;
    end
  end

  pdb_div_if div_if [N_DIV] ();

  genvar g;
  generate
    for (g = 0; g < N_DIV; g++) begin : g_div
      assign div_if[g].tick  = tick;
      assign div_if[g].clear = div_clr;
      assign div_if[g].div_n = div_n[g];
      assign q[g]            = div_if[g].clk_q;
      pdb_divider u_div (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d     (div_if[g])
      );
    end
  endgenerate

  // Four copies per bank, feedback on its own divider
  assign raw = {q[3], {4{q[2]}}, {4{q[1]}}, {4{q[0]}}};

  // Sync: common count over the A/C repeat length
  assign sup_len       = pdb_lcm(div_n[0], div_n[2]);
  assign fast_per      = (div_n[0] < div_n[2]) ? div_n[0] : div_n[2];
  assign sup_wrap      = (sup_ff >= SUP_W'(sup_len - 5'h01));
  assign nxt_sup_start = div_clr | (sup_start_ff & ~tick);
  assign nxt_sup       = div_clr ? '0 : !tick ? sup_ff : (sup_start_ff | sup_wrap) ? '0 : SUP_W'(sup_ff + 5'h01);
  // With equal A and C rates every edge coincides, so sync then stays low
  assign nxt_sync_n    = nxt_sup_start ? 1'b1 : (nxt_sup < SUP_W'(sup_len - fast_per));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sup_ff       <= '0;
      sup_start_ff <= 1'b1;
      sync_n_ff    <= 1'b1;
    end else begin
      sup_ff       <= nxt_sup;
      sup_start_ff <= nxt_sup_start;
      sync_n_ff    <= nxt_sync_n;
    end
  end

  // Length of the current sync low run, checked below
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_lo_ff <= 6'h00;
    end else begin
      sync_lo_ff <= sync_n_ff ? 6'h00 : 6'(sync_lo_ff + 6'h01);
    end
  end

  pdb_freeze_rx u_frz (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .freeze_clk_i  (freeze_clk_i),
    .freeze_data_i (freeze_data_i),
    .frz_mask_o    (frz_mask)
  );

  // Freeze and invert change only while the visible level is low, so freeze never makes a runt
  generate
    for (g = 0; g < N_OUT; g++) begin : g_out
      assign inv_tgt[g]     = ctrl_ff[CTRL_INV] & INV_MASK[g];
      assign vis[g]         = raw[g] ^ inv_eff_ff[g];
      assign nxt_inv_eff[g] = vis[g] ? inv_eff_ff[g] : inv_tgt[g];
      assign nxt_frz_eff[g] = vis[g] ? frz_eff_ff[g] : frz_mask[g];
      assign nxt_out[g]     = vis[g] & ~frz_eff_ff[g] & mroe;

      a_frz_when_low: assert property (@(posedge clk_i) disable iff (rst_i)
                                       $changed(frz_eff_ff[g]) |-> !$past(vis[g]))
        else $error("freeze changed while output high");
      a_frz_holds: assert property (@(posedge clk_i) disable iff (rst_i)
                                    $past(frz_eff_ff[g]) |-> !out_ff[g])
        else $error("frozen output not low");
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      inv_eff_ff <= '0;
      frz_eff_ff <= '0;
      out_ff     <= '0;
      oe_ff      <= 1'b0;
    end else begin
      inv_eff_ff <= nxt_inv_eff;
      frz_eff_ff <= nxt_frz_eff;
      out_ff     <= nxt_out;
      oe_ff      <= mroe;
    end
  end

  // Lock monitor: loop closes only through the returned feedback pin
  assign fb_active    = (fb_watch_ff != '0);
  assign nxt_fb_watch = (fb_return_i != fb_prev_ff) ? FB_WATCH_CYCLES :
                        fb_active ? FB_WATCH_W'(fb_watch_ff - 8'h01) : fb_watch_ff;
  assign lock_restart = clr | ~fb_active | (wr_ctrl & (nxt_ctrl != ctrl_ff));
  assign nxt_lock_cnt = lock_restart ? '0 :
                        (lock_cnt_ff == LCW'(LOCK_CYCLES)) ? lock_cnt_ff : LCW'(lock_cnt_ff + 1'b1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fb_prev_ff  <= 1'b0;
      fb_watch_ff <= '0;
      lock_cnt_ff <= '0;
      lock_ff     <= 1'b0;
    end else begin
      fb_prev_ff  <= fb_return_i;
      fb_watch_ff <= nxt_fb_watch;
      lock_cnt_ff <= nxt_lock_cnt;
      lock_ff     <= (nxt_lock_cnt == LCW'(LOCK_CYCLES));
    end
  end

  assign avs_readdata_o    = rdata_ff;
  assign avs_waitrequest_o = wait_ff;
  assign bank_a_outputs_o  = out_ff[3:0];
  assign bank_b_outputs_o  = out_ff[7:4];
  assign bank_c_outputs_o  = out_ff[11:8];
  assign feedback_output_o = out_ff[IDX_FB];
  assign sync_n_o          = sync_n_ff;
  assign outputs_enable_o  = oe_ff;
  assign pll_locked_o      = lock_ff;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_coincide;
    $rose(q[0]) && $rose(q[2]);
  endsequence
  sequence s_sync_end;
    $rose(sync_n_ff) && !$past(div_clr);
  endsequence

  a_sync_coinc: assert property (s_sync_end |-> s_coincide)
    else $error("sync release not at coincident A/C rise");
  a_prediv_gap: assert property (!ctrl_ff[CTRL_VCO] && !clr && tick ##1 !clr && !ctrl_ff[CTRL_VCO] |-> !tick)
    else $error("halving prediv produced back to back ticks");
  a_lock_time: assert property ($rose(lock_ff) |-> $past(lock_cnt_ff) == LCW'(LOCK_CYCLES - 1))
    else $error("lock flagged at wrong count");
  a_lock_drop: assert property (!fb_active |=> !lock_ff)
    else $error("lock held without feedback return");
  a_fb_double: assert property (ctrl_ff[CTRL_RANGE] |-> div_n[3] == 5'h08 + 5'h04 * ctrl_ff[CTRL_FB_LSB +: 2])
    else $error("range bit did not double feedback divide");
  a_inv_low: assert property ($changed(inv_eff_ff[10]) |-> !$past(vis[10]))
    else $error("invert applied while output high");
  a_reset_clear: assert property (clr |=> out_ff == '0 && !oe_ff && q == '0)
    else $error("master reset left outputs running");
  a_bus_answer: assert property (req && wait_ff |=> !wait_ff ##1 wait_ff)
    else $error("bus answer not one wait cycle");
  a_sync_width: assert property (s_sync_end |->
                                 sync_lo_ff == (ctrl_ff[CTRL_VCO] ? 6'(fast_per) : 6'(fast_per) << 1))
    else $error("sync low not one faster period");
  a_resync_clear: assert property (resync |=> q == '0 && sup_ff == '0)
    else $error("select change did not restart dividers");
endmodule
`default_nettype wire

// file: rtl/pdb_pkg.sv
// Shared constants, types and lookup functions of the PLL output divider bank.
`default_nettype none
package pdb_pkg;
  localparam int DIV_W    = 5;
  localparam int SUP_W    = 5;
  localparam int N_DIV    = 4;
  localparam int N_OUT    = 13;
  localparam int IDX_FB   = 12;
  localparam logic [N_OUT-1:0] INV_MASK = 13'h0C00;
  // Avalon byte offsets, decoded on address bits [3:2]
  localparam logic [3:0] OFF_CTRL   = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  // Control register fields
  localparam int CTRL_A_LSB  = 0;
  localparam int CTRL_B_LSB  = 2;
  localparam int CTRL_C_LSB  = 4;
  localparam int CTRL_FB_LSB = 6;
  localparam int CTRL_RANGE  = 8;
  localparam int CTRL_VCO    = 9;
  localparam int CTRL_INV    = 10;
  localparam int CTRL_MROE   = 11;
  localparam int CTRL_W      = 12;
  localparam logic [CTRL_W-1:0] CTRL_RST = 12'hBFF;
  // Status register fields
  localparam int STAT_LOCK    = 0;
  localparam int STAT_FB_ACT  = 1;
  localparam int STAT_SYNC    = 2;
  localparam int STAT_FRZ_LSB = 16;
  // Timing
  localparam int CLK_HZ           = 20_000_000;
  localparam int LOCK_TIME_MS     = 10;
  localparam int LOCK_CYCLES_DFLT = LOCK_TIME_MS * (CLK_HZ / 1000);
  localparam int FRZ_CLK_MAX_MHZ  = 20;
  localparam int FB_WATCH_W       = 8;
  localparam logic [FB_WATCH_W-1:0] FB_WATCH_CYCLES = 8'hFF;

  typedef logic [DIV_W-1:0] pdb_div_t;
  typedef enum logic [1:0] {FRZ_IDLE = 2'b00, FRZ_SHIFT = 2'b01, FRZ_LOAD = 2'b11} pdb_frz_state_t;

  function automatic pdb_div_t pdb_bank_div(input logic [1:0] bank, input logic [1:0] sel);
    case ({bank, sel})
      4'h0: return 5'h04;
      4'h1: return 5'h06;
      4'h2: return 5'h08;
      4'h3: return 5'h0C;
      4'h4: return 5'h04;
      4'h5: return 5'h06;
      4'h6: return 5'h08;
      4'h7: return 5'h0A;
      4'h8: return 5'h02;
      4'h9: return 5'h04;
      4'hA: return 5'h06;
      default: return 5'h08;
    endcase
  endfunction

  function automatic pdb_div_t pdb_fb_div(input logic dbl, input logic [1:0] sel);
    pdb_div_t base;
    case (sel)
      2'h0: base = 5'h04;
      2'h1: base = 5'h06;
      2'h2: base = 5'h08;
      default: base = 5'h0A;
    endcase
    return dbl ? {base[DIV_W-2:0], 1'b0} : base;
  endfunction

  // Smallest common multiple of two bank divides, searched downward
  function automatic logic [SUP_W-1:0] pdb_lcm(input pdb_div_t x, input pdb_div_t y);
    logic [9:0] m;
    logic [SUP_W-1:0] r;
    r = '0;
    for (int k = 12; k >= 1; k--) begin
      m = 10'(x) * 10'(k);
      if ((m % 10'(y)) == 10'h000) r = m[SUP_W-1:0];
    end
    return r;
  endfunction
endpackage
`default_nettype wire

// file: rtl/pdb_div_if.sv
// Control and output bundle between the top and one output divider.
`default_nettype none
interface pdb_div_if;
  import pdb_pkg::*;
  logic     tick;
  logic     clear;
  pdb_div_t div_n;
  logic     clk_q;
  modport core (input tick, input clear, input div_n, output clk_q);
  modport ctl  (output tick, output clear, output div_n, input clk_q);
endinterface
`default_nettype wire

// file: rtl/pdb_divider.sv
// Even integer divider producing a half-duty clock on enable ticks.
`default_nettype none
module pdb_divider
  import pdb_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  pdb_div_if.core   d
);
  pdb_div_t cnt_ff;
  pdb_div_t nxt_cnt;
  pdb_div_t half;
  logic     q_ff;
  logic     nxt_q;
  logic     start_ff;
  logic     nxt_start;
  logic     wrap;

  assign half      = d.div_n >> 1;
  assign wrap      = (cnt_ff >= pdb_div_t'(d.div_n - 5'h01));
  // After clear the first tick is a rising edge, shared by every divider
  assign nxt_start = d.clear | (start_ff & ~d.tick);
  assign nxt_cnt   = d.clear ? '0 : !d.tick ? cnt_ff : (start_ff | wrap) ? '0 : pdb_div_t'(cnt_ff + 5'h01);
  assign nxt_q     = (d.clear | (start_ff & ~d.tick)) ? 1'b0 : (nxt_cnt < half);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff   <= '0;
      q_ff     <= 1'b0;
      start_ff <= 1'b1;
    end else begin
      cnt_ff   <= nxt_cnt;
      q_ff     <= nxt_q;
      start_ff <= nxt_start;
    end
  end

  assign d.clk_q = q_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_wrap_rises: assert property (d.tick && !d.clear && !start_ff && wrap |=> cnt_ff == '0 && q_ff)
    else $error("divider wrap did not raise the output");
  a_half_falls: assert property (d.tick && !d.clear && !start_ff && !wrap && cnt_ff == pdb_div_t'(half - 5'h01)
                                 |=> !q_ff)
    else $error("divider output not low after half period");
endmodule
`default_nettype wire

// file: rtl/pdb_freeze_rx.sv
// Serial freeze port receiver: start bit then one freeze bit per output.
`default_nettype none
module pdb_freeze_rx
  import pdb_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             freeze_clk_i,
  input  wire logic             freeze_data_i,
  output logic [N_OUT-1:0]      frz_mask_o
);
  pdb_frz_state_t   state_ff;
  pdb_frz_state_t   nxt_state;
  logic             fclk_prev_ff;
  logic [3:0]       bit_cnt_ff;
  logic [3:0]       nxt_bit_cnt;
  logic [N_OUT-1:0] shift_ff;
  logic [N_OUT-1:0] nxt_shift;
  logic [N_OUT-1:0] mask_ff;
  logic             fclk_rise;
  logic             last_bit;

  // Edge found by sampling, so the freeze clock must stay well under clk_i
  assign fclk_rise = freeze_clk_i & ~fclk_prev_ff;
  assign last_bit  = (bit_cnt_ff == 4'(N_OUT - 1));

  always_comb begin
    nxt_state   = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift   = shift_ff;
    case (state_ff)
      FRZ_IDLE: begin
        if (fclk_rise && !freeze_data_i) begin
          nxt_state   = FRZ_SHIFT;
          nxt_bit_cnt = 4'h0;
        end
      end
      FRZ_SHIFT: begin
        if (fclk_rise) begin
          nxt_shift[bit_cnt_ff] = freeze_data_i;
          nxt_bit_cnt           = 4'(bit_cnt_ff + 4'h1);
          if (last_bit) nxt_state = FRZ_LOAD;
        end
      end
      FRZ_LOAD: nxt_state = FRZ_IDLE;
      default:  nxt_state = FRZ_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff     <= FRZ_IDLE;
      fclk_prev_ff <= 1'b0;
      bit_cnt_ff   <= 4'h0;
      shift_ff     <= '0;
      mask_ff      <= '0;
    end else begin
      state_ff     <= nxt_state;
      fclk_prev_ff <= freeze_clk_i;
      bit_cnt_ff   <= nxt_bit_cnt;
      shift_ff     <= nxt_shift;
      mask_ff      <= (state_ff == FRZ_LOAD) ? shift_ff : mask_ff;
    end
  end

  assign frz_mask_o = mask_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_frz_load: assert property (state_ff == FRZ_LOAD |=> frz_mask_o == $past(shift_ff) && state_ff == FRZ_IDLE)
    else $error("freeze mask not loaded from frame");
endmodule
`default_nettype wire

// file: tb/pdb_board.sv
// Board-side partner: feedback loop wiring and freeze port frames.
`default_nettype none
module pdb_board (
  input  wire logic clk_i,
  input  wire logic feedback_output_i,
  input  wire logic fb_cut_i,
  output logic      freeze_clk_o,
  output logic      freeze_data_o,
  output logic      fb_return_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // A cut feedback trace floats to the pin's pull-up level
  assign fb_return_o = fb_cut_i ? 1'b1 : feedback_output_i;
  initial begin
    freeze_clk_o  = 1'b0;
    freeze_data_o = 1'b1;
  end
  // Three cycles high, four low per bit: slow clock, within the port limit
  task automatic send_frame(input logic [12:0] mask);
    logic [13:0] bits;
    bits = {mask, 1'b0};
    for (int i = 0; i < 14; i++) begin
      @(posedge clk_i);
      freeze_data_o <= bits[i];
      repeat (3) @(posedge clk_i);
      freeze_clk_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      freeze_clk_o <= 1'b0;
    end
    @(posedge clk_i);
    freeze_data_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// file: tb/pll_output_divider_bank_bench.sv
// Self-checking bench of the PLL output divider bank.
`default_nettype none
module pll_output_divider_bank_bench;
  import pdb_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LOCK_N = 50;
  localparam int A_DIV[4] = '{4, 6, 8, 12};
  localparam int B_DIV[4] = '{4, 6, 8, 10};
  localparam int C_DIV[4] = '{2, 4, 6, 8};
  localparam int F_DIV[4] = '{4, 6, 8, 10};
  typedef struct {logic [31:0] v; logic [31:0] m;} pdb_exp_t;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [3:0]  avs_address_i = 4'h0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        freeze_clk_i;
  logic        freeze_data_i;
  logic        fb_return_i;
  logic        fb_cut = 1'b0;
  logic [3:0]  bank_a_outputs_o;
  logic [3:0]  bank_b_outputs_o;
  logic [3:0]  bank_c_outputs_o;
  logic        feedback_output_o;
  logic        sync_n_o;
  logic        outputs_enable_o;
  logic        pll_locked_o;
  logic [31:0] seed = 32'h978786DE;
  int          n_fail = 0;
  int          n_tests = 0;
  pdb_exp_t    exp_q[$];

  always #25 clk_i = ~clk_i;

  pdb_top #(.LOCK_CYCLES(LOCK_N)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .freeze_clk_i(freeze_clk_i),
    .freeze_data_i(freeze_data_i), .fb_return_i(fb_return_i), .bank_a_outputs_o(bank_a_outputs_o),
    .bank_b_outputs_o(bank_b_outputs_o), .bank_c_outputs_o(bank_c_outputs_o),
    .feedback_output_o(feedback_output_o), .sync_n_o(sync_n_o), .outputs_enable_o(outputs_enable_o),
    .pll_locked_o(pll_locked_o));

  pdb_board u_board (
    .clk_i(clk_i), .feedback_output_i(feedback_output_o), .fb_cut_i(fb_cut),
    .freeze_clk_o(freeze_clk_i), .freeze_data_o(freeze_data_i), .fb_return_o(fb_return_i));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int lcm(input int x, input int y);
    int m;
    m = x;
    while (m % y != 0) m += x;
    return m;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_verdict();
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Read results are judged where they appear, against the oldest note
  always @(posedge clk_i) begin
    pdb_exp_t e;
    if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0) begin
      if (exp_q.size() == 0) begin
        chk("read_unexpected", 32'h0, 32'hFFFFFFFF);
      end else begin
        e = exp_q.pop_front();
        chk("readdata", e.v, avs_readdata_o & e.m);
      end
    end
  end

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    avs_address_i    <= a;
    avs_writedata_i  <= d;
    avs_byteenable_i <= be;
    avs_write_i      <= wr;
    avs_read_i       <= ~wr;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    pdb_exp_t x;
    x.v = e;
    x.m = m;
    exp_q.push_back(x);
    bus(1'b0, a, 32'h0, 4'h0);
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return bank_a_outputs_o[0];
      1: return bank_b_outputs_o[0];
      2: return bank_c_outputs_o[0];
      3: return feedback_output_o;
      default: return sync_n_o;
    endcase
  endfunction

  // Cycles up to the next rising edge, and low samples among them
  task automatic rise(input int k, output int n, output int lo);
    logic p;
    logic c;
    n = 0;
    lo = 0;
    p = 1'b1;
    c = 1'b1;
    while (!(p === 1'b0 && c === 1'b1)) begin
      @(posedge clk_i);
      p = c;
      c = sig(k);
      n++;
      if (c === 1'b0) lo++;
    end
  endtask

  initial begin
    repeat (40000) @(posedge clk_i);
    n_fail++;
    give_verdict();
  end

  initial begin
    logic [31:0] r;
    logic [11:0] cfg;
    int n, lo, tk, bad;
    int dv[4];
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(4'h0, 32'h00000BFF, 32'hFFFFFFFF);
    rd(4'hC, 32'h0, 32'hFFFFFFFF);
    bus(1'b1, 4'h8, 32'hFFFFFFFF, 4'hF);
    bus(1'b1, 4'h4, 32'hFFFFFFFF, 4'hF);
    bus(1'b1, 4'h0, 32'h00000000, 4'h2);
    rd(4'h0, 32'h000000FF, 32'hFFFFFFFF);
    repeat (3) @(posedge clk_i);
    chk("outputs_off", 14'h0, {outputs_enable_o, bank_a_outputs_o, bank_b_outputs_o, bank_c_outputs_o,
        feedback_output_o});
    bus(1'b1, 4'h0, 32'h0000_0A72, 4'hF);
    rise(0, n, lo);
    chk("aligned", 4'hF, {outputs_enable_o, sig(1), sig(2), sig(3)});
    for (int t = 0; t < 8; t++) begin
      r = xs();
      cfg = {1'b1, r[10:0]};
      if (t < 4) cfg[7:0] = {4{t[1:0]}};
      bus(1'b1, 4'h0, {20'h0, cfg}, 4'hF);
      repeat (200) @(posedge clk_i);
      tk = cfg[9] ? 1 : 2;
      dv[0] = A_DIV[cfg[1:0]];
      dv[1] = B_DIV[cfg[3:2]];
      dv[2] = C_DIV[cfg[5:4]];
      dv[3] = F_DIV[cfg[7:6]] * (cfg[8] ? 2 : 1);
      for (int k = 0; k < 4; k++) begin
        rise(k, n, lo);
        rise(k, n, lo);
        chk("period", 32'(dv[k] * tk), 32'(n));
        chk("low_half", 32'(dv[k] * tk / 2), 32'(lo));
      end
      if (dv[0] != dv[2]) begin
        rise(4, n, lo);
        rise(4, n, lo);
        chk("sync_period", 32'(lcm(dv[0], dv[2]) * tk), 32'(n));
        chk("sync_low", 32'((dv[0] < dv[2] ? dv[0] : dv[2]) * tk), 32'(lo));
      end
      bad = 0;
      repeat (30) begin
        @(posedge clk_i);
        if (bank_c_outputs_o !== {{2{bank_c_outputs_o[0] ^ cfg[10]}}, {2{bank_c_outputs_o[0]}}}) bad++;
      end
      chk("invert", 32'h0, 32'(bad));
      rd(4'h4, 32'h3, 32'h3);
    end
    bus(1'b1, 4'h0, 32'h0000_0A72, 4'hF);
    repeat (50) @(posedge clk_i);
    u_board.send_frame(13'h0801);
    repeat (20) @(posedge clk_i);
    rd(4'h4, 32'h08010000, 32'h1FFF0000);
    bad = 0;
    repeat (40) begin
      @(posedge clk_i);
      if (bank_a_outputs_o[0] !== 1'b0 || bank_c_outputs_o[3] !== 1'b0) bad++;
    end
    chk("frozen_low", 32'h0, 32'(bad));
    u_board.send_frame(13'h0000);
    repeat (40) @(posedge clk_i);
    bad = 0;
    repeat (40) begin
      @(posedge clk_i);
      if (bank_a_outputs_o[0] !== bank_a_outputs_o[1]) bad++;
    end
    chk("unfrozen_phase", 32'h0, 32'(bad));
    fb_cut <= 1'b1;
    repeat (300) @(posedge clk_i);
    rd(4'h4, 32'h0, 32'h3);
    fb_cut <= 1'b0;
    repeat (LOCK_N + 100) @(posedge clk_i);
    chk("relock", 1'b1, pll_locked_o);
    repeat (3) @(posedge clk_i);
    give_verdict();
  end
endmodule
`default_nettype wire
